// file: verilog/spc_defines.vh
// Constants for the stop mode power controller.
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH
`define SPC_ADR_CTRL      4'h0
`define SPC_ADR_STAT      4'h4
`define SPC_ADR_CLKCFG    4'h8
`define SPC_ADR_SNAP      4'hC
`define SPC_CTRL_STOP_INSTR_ENABLE    0
`define SPC_CTRL_PARTIAL_POWERDOWN_SELECT     1
`define SPC_CTRL_LOWVOLT_DETECT_ENABLE     2
`define SPC_CTRL_LOWVOLT_STOP_ENABLE    3
`define SPC_CTRL_DEBUG_MODE_ENABLE    4
`define SPC_CTRL_RTCEN    5
`define SPC_CTRL_ADCAE    6
`define SPC_CTRL_RST      8'h01
`define SPC_STAT_FLAG     0
`define SPC_STAT_ACK      1
`define SPC_CFG_IRCLK     0
`define SPC_CFG_IRSTEN    1
`define SPC_CFG_ERCLK     2
`define SPC_CFG_ERSTEN    3
`define SPC_CFG_RANGE     4
`define SPC_CFG_RST       8'h00
`define SPC_POR_NS        2000
`define SPC_POR_CYC       8'h32
`define SPC_PINS          8
`endif

// file: verilog/spc_pin_latch.v
// Pin control latch memory for the stop mode power controller.
`timescale 1ns/1ns
`default_nettype none
module spc_pin_latch
(
    input  wire        clk_i,
    input  wire        we_i,
    input  wire [15:0] wdata_i,
    output reg  [15:0] rdata_o
);
    reg [15:0] mem_r;
    always @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_r <= wdata_i;
        end
        rdata_o <= we_i ? wdata_i : mem_r;
    end
endmodule // spc_pin_latch
`default_nettype wire

// file: verilog/spc_stop_ctrl.v
// Stop mode power controller with Wishbone register access.
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "spc_defines.vh"
// Functional notes
// - Stop instruction enters a stop mode only while stop enable is set.
// - Stop2 powers down almost everything but keeps RAM powered.
// - Entering stop2 latches all pin control signals for the whole stop.
// - Reset pin assertion exits stop2.
// - Old masks: active-low wake pin wakes stop2; software sets it input.
// - Old masks: wake pin ignored when configured as high driven output.
// - Enabled real-time counter event wakes from stop2.
// - Stop2 wake restarts like power-on, resetting module registers.
// - After stop2 wake, low trip voltage reset holds device while supply low.
// - After stop2 wake the CPU starts at the reset vector.
// - Stop2 wake sets the recovery flag.
// - Flag and pin latches stay until software writes one to acknowledge.
// - Software restores port registers before acknowledge, else reset states.
// - Open latches with peripheral disabled let port registers drive pin.
// - Any stop mode gates all peripheral clocks, even with debug enabled.
// - Stop3 converter runs only with async clock and detector enabled.
// - Stop3 internal reference runs only with both its enable bits set.
// - Stop3 crystal oscillator runs only with both its enable bits set.
// - High range oscillator in stop3 also needs the voltage detector.
// - Stop3 regulator stays active with detector or debug enabled.
// - Real-time counter runs in stop only when it is enabled.
// - Stop2 request with debug enabled enters stop3 instead.
// - Stop2 request with low-voltage stop enable set enters stop3.
module spc_stop_ctrl
#(
    parameter OLD_MASK = 1'b1
)
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire        stop_instr_i,
    input  wire        reset_pin_n_i,
    input  wire        shared_wake_pin_n_i,
    input  wire        wake_pin_is_out_i,
    input  wire        wake_pin_out_high_i,
    input  wire        rtc_event_i,
    input  wire        supply_low_i,
    input  wire [7:0]  port_dat_i,
    input  wire [7:0]  port_dir_i,
    input  wire [7:0]  periph_en_i,
    input  wire [7:0]  periph_dat_i,
    input  wire [7:0]  periph_dir_i,
    output wire [7:0]  pin_o,
    output wire [7:0]  pin_oe_o,
    output reg         illegal_stop_o,
    output wire        cpu_reset_o,
    output wire        fetch_reset_vector_o,
    output wire        module_reset_o,
    output wire        ram_power_o,
    output wire        core_power_o,
    output wire        periph_clk_en_o,
    output wire        debug_clk_en_o,
    output wire        adc_run_o,
    output wire        irc_run_o,
    output wire        crystal_oscillator_run_o,
    output wire        vreg_active_o,
    output wire        rtc_run_o,
    output wire        lvd_low_trip_o,
    output wire [1:0]  mode_o
);
    // ************************************************************
    // Mode state and power-on reset.
    // ************************************************************
    localparam [1:0] ST_RUN   = 2'b00;
    localparam [1:0] ST_STOP3 = 2'b01;
    localparam [1:0] ST_STOP2 = 2'b10;
    localparam [1:0] ST_WAKE  = 2'b11;

    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [7:0]  ctrl_r;
    reg [7:0]  clkcfg_r;
    reg        flag_r;
    reg        latched_r;
    reg [7:0]  por_cnt_r;
    reg        rst_meta_r;
    reg        rst_sync_r;
    reg        wake_meta_r;
    reg        wake_sync_r;
    reg        ack_r;
    wire       wb_req;
    wire       wr_ctrl;
    wire       wr_stat;
    wire       ack_wr;
    wire       wake_ok;
    wire       in_stop;
    wire       lat_we;
    wire [15:0] lat_q;
    wire [7:0] live_dat;
    wire [7:0] live_dir;

    function [7:0] pick;
        input [7:0] sel;
        input [7:0] a;
        input [7:0] b;
        begin
            pick = (sel & a) | (~sel & b);
        end
    endfunction

    // ************************************************************
    // Input synchronisers.
    // ************************************************************
    always @(posedge clk_i)
    begin
        rst_meta_r  <= ~reset_pin_n_i;
        rst_sync_r  <= rst_meta_r;
        wake_meta_r <= ~shared_wake_pin_n_i;
        wake_sync_r <= wake_meta_r;
    end

    // ************************************************************
    // Stop entry and wake-up.
    // ************************************************************
    assign wake_ok = rst_sync_r
        | (OLD_MASK & wake_sync_r
           & ~(wake_pin_is_out_i & wake_pin_out_high_i))
        | (ctrl_r[`SPC_CTRL_RTCEN] & rtc_event_i);
    assign in_stop = (state_r == ST_STOP3) | (state_r == ST_STOP2);

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
            begin
                if (stop_instr_i & ctrl_r[`SPC_CTRL_STOP_INSTR_ENABLE])
                begin
                    if (ctrl_r[`SPC_CTRL_PARTIAL_POWERDOWN_SELECT] & ~ctrl_r[`SPC_CTRL_DEBUG_MODE_ENABLE]
                        & ~ctrl_r[`SPC_CTRL_LOWVOLT_STOP_ENABLE])
                    begin
                        state_nxt = ST_STOP2;
                    end
                    else
                    begin
                        state_nxt = ST_STOP3;
                    end
                end
            end
            ST_STOP3:
            begin
                if (wake_ok)
                begin
                    state_nxt = ST_RUN;
                end
            end
            ST_STOP2:
            begin
                if (wake_ok)
                begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE:
            begin
                if ((por_cnt_r == 8'h00) & ~supply_low_i)
                begin
                    state_nxt = ST_RUN;
                end
            end
            default:
            begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r        <= ST_RUN;
            por_cnt_r      <= 8'h00;
            illegal_stop_o <= 1'b0;
        end
        else
        begin
            state_r        <= state_nxt;
            illegal_stop_o <= (state_r == ST_RUN) & stop_instr_i
                              & ~ctrl_r[`SPC_CTRL_STOP_INSTR_ENABLE];
            if ((state_r == ST_STOP2) & wake_ok)
            begin
                por_cnt_r <= `SPC_POR_CYC;
            end
            else if ((state_r == ST_WAKE) & (por_cnt_r != 8'h00))
            begin
                por_cnt_r <= por_cnt_r - 8'h01;
            end
        end
    end

    // ************************************************************
    // Wishbone register slave.
    // ************************************************************
    assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wb_ack_o = ack_r;
    assign wr_ctrl  = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SPC_ADR_CTRL);
    assign wr_stat  = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SPC_ADR_STAT);
    assign ack_wr   = wr_stat & wb_dat_i[`SPC_STAT_ACK];

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_r   <= `SPC_CTRL_RST;
            clkcfg_r <= `SPC_CFG_RST;
            flag_r   <= 1'b0;
            latched_r <= 1'b0;
        end
        else
        begin
            ack_r <= wb_req;
            if (wb_req & ~wb_we_i)
            begin
                case (wb_adr_i)
                    `SPC_ADR_CTRL:   wb_dat_o <= {24'h000000, ctrl_r};
                    `SPC_ADR_STAT:   wb_dat_o <= {31'h00000000, flag_r};
                    `SPC_ADR_CLKCFG: wb_dat_o <= {24'h000000, clkcfg_r};
                    `SPC_ADR_SNAP:   wb_dat_o <= {16'h0000, lat_q};
                    default:         wb_dat_o <= 32'h0000_0000;
                endcase
            end
            if ((state_r == ST_STOP2) & wake_ok)
            begin
                ctrl_r   <= `SPC_CTRL_RST;
                clkcfg_r <= `SPC_CFG_RST;
            end
            else
            begin
                if (wr_ctrl)
                begin
                    ctrl_r <= wb_dat_i[7:0];
                end
                if (wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SPC_ADR_CLKCFG))
                begin
                    clkcfg_r <= wb_dat_i[7:0];
                end
            end
            if (state_nxt == ST_STOP2 && state_r == ST_RUN)
            begin
                latched_r <= 1'b1;
            end
            else if (ack_wr & (state_r == ST_RUN))
            begin
                latched_r <= 1'b0;
            end
            if ((state_r == ST_STOP2) & wake_ok)
            begin
                flag_r <= 1'b1;
            end
            else if (ack_wr & (state_r == ST_RUN))
            begin
                flag_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Pin latches and pin drive.
    // ************************************************************
    assign live_dat = pick(periph_en_i, periph_dat_i, port_dat_i);
    assign live_dir = pick(periph_en_i, periph_dir_i, port_dir_i);
    assign lat_we   = ~latched_r;

    spc_pin_latch u_latch
    (
        .clk_i   (clk_i),
        .we_i    (lat_we),
        .wdata_i ({live_dir, live_dat}),
        .rdata_o (lat_q)
    );

    assign pin_o    = lat_q[7:0];
    assign pin_oe_o = lat_q[15:8];

    // ************************************************************
    // Power and clock outputs.
    // ************************************************************
    assign mode_o               = state_r;
    assign cpu_reset_o          = (state_r == ST_WAKE);
    assign module_reset_o       = (state_r == ST_WAKE);
    assign fetch_reset_vector_o = (state_r == ST_WAKE) & (state_nxt == ST_RUN);
    assign lvd_low_trip_o       = (state_r == ST_WAKE);
    assign ram_power_o          = 1'b1;
    assign core_power_o         = (state_r != ST_STOP2);
    assign periph_clk_en_o      = ~in_stop;
    assign debug_clk_en_o       = ~in_stop | ((state_r == ST_STOP3) & ctrl_r[`SPC_CTRL_DEBUG_MODE_ENABLE]);
    assign adc_run_o  = ~in_stop | ((state_r == ST_STOP3) & ctrl_r[`SPC_CTRL_ADCAE]
                        & ctrl_r[`SPC_CTRL_LOWVOLT_DETECT_ENABLE]);
    assign irc_run_o  = ~in_stop | ((state_r == ST_STOP3) & clkcfg_r[`SPC_CFG_IRCLK]
                        & clkcfg_r[`SPC_CFG_IRSTEN]);
    assign crystal_oscillator_run_o = ~in_stop | ((state_r == ST_STOP3) & clkcfg_r[`SPC_CFG_ERCLK]
                        & clkcfg_r[`SPC_CFG_ERSTEN]
                        & (~clkcfg_r[`SPC_CFG_RANGE] | ctrl_r[`SPC_CTRL_LOWVOLT_DETECT_ENABLE]));
    assign vreg_active_o = ~in_stop | ((state_r == ST_STOP3)
                        & (ctrl_r[`SPC_CTRL_LOWVOLT_DETECT_ENABLE] | ctrl_r[`SPC_CTRL_DEBUG_MODE_ENABLE]));
    assign rtc_run_o  = ~in_stop | ctrl_r[`SPC_CTRL_RTCEN];
endmodule // spc_stop_ctrl
`default_nettype wire

// file: testbench/spc_asserts.sv
// Concurrent checks on the stop mode power controller ports.
`timescale 1ns/1ns
`default_nettype none
module spc_asserts
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       stop_instr_i,
    input wire logic       reset_pin_n_i,
    input wire logic       supply_low_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    input wire logic       cpu_reset_o,
    input wire logic       fetch_reset_vector_o,
    input wire logic       module_reset_o,
    input wire logic       ram_power_o,
    input wire logic       core_power_o,
    input wire logic       periph_clk_en_o,
    input wire logic       lvd_low_trip_o,
    input wire logic [1:0] mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_enter_stop;
        mode_o == 2'h0 ##1 (mode_o == 2'h1 || mode_o == 2'h2);
    endsequence
    sequence s_pin_low_in_stop2;
        (mode_o == 2'h2 && !reset_pin_n_i) [*3];
    endsequence
    sequence s_low_in_wake;
        (mode_o == 2'h3 && supply_low_i) [*3];
    endsequence
    AST_STOP_CAUSE: assert property (s_enter_stop |-> $past(stop_instr_i))
        else $error("stop mode entered without a stop instruction");
    AST_RAM_ON: assert property (ram_power_o)
        else $error("ram power dropped");
    AST_CORE_OFF: assert property (mode_o == 2'h2 |-> !core_power_o)
        else $error("core powered in stop2");
    AST_PIN_HOLD: assert property (mode_o == 2'h2 && $past(mode_o, 2) == 2'h2
        |-> $stable(pin_o) && $stable(pin_oe_o))
        else $error("pin changed in stop2");
    AST_RESET_PIN_WAKE: assert property (s_pin_low_in_stop2 |=> mode_o == 2'h3)
        else $error("reset pin did not end stop2");
    AST_WAKE_RESET: assert property (mode_o == 2'h3
        |-> cpu_reset_o && module_reset_o && lvd_low_trip_o)
        else $error("wake state without resets");
    AST_LOW_SUPPLY_HOLD: assert property (s_low_in_wake |=> mode_o == 2'h3)
        else $error("left reset while supply low");
    AST_VECTOR_RUN: assert property (fetch_reset_vector_o
        |-> mode_o == 2'h3 ##1 mode_o == 2'h0)
        else $error("vector fetch outside wake end");
    AST_PERIPH_GATE: assert property (mode_o == 2'h1 || mode_o == 2'h2
        |-> !periph_clk_en_o)
        else $error("peripheral clock on in stop");
endmodule // spc_asserts
bind spc_stop_ctrl spc_asserts u_chk (.clk_i, .rst_i, .stop_instr_i, .reset_pin_n_i,
    .supply_low_i, .pin_o, .pin_oe_o, .cpu_reset_o, .fetch_reset_vector_o, .module_reset_o,
    .ram_power_o, .core_power_o, .periph_clk_en_o, .lvd_low_trip_o, .mode_o);
`default_nettype wire

// file: testbench/spc_far_side.sv
// Model of the reset pin and the shared wake pin outside the controller.
`timescale 1ns/1ns
`default_nettype none
module spc_far_side
(
    input  wire logic clk_i,
    input  wire logic press_reset_i,
    input  wire logic press_wake_i,
    output var  logic reset_pin_n_o,
    output var  logic wake_pin_n_o
);
    // Both pins rest high on their pull-ups and go low only while pressed.
    always @(posedge clk_i)
    begin
        reset_pin_n_o <= !press_reset_i;
        wake_pin_n_o <= !press_wake_i;
    end
endmodule // spc_far_side
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking testbench for the stop mode power controller.
`timescale 1ns/1ns
`default_nettype none
`include "spc_defines.vh"
module tb_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, stop_instr_i = 1'b0, reset_pin_n_i, shared_wake_pin_n_i;
    logic        wake_pin_is_out_i = 1'b0, wake_pin_out_high_i = 1'b0, rtc_event_i = 1'b0;
    logic        supply_low_i = 1'b0, press_reset_i = 1'b0, press_wake_i = 1'b0;
    logic [7:0]  port_dat_i = 8'hA5, port_dir_i = 8'hFF, periph_en_i = 8'h00;
    logic [7:0]  periph_dat_i = 8'h00, periph_dir_i = 8'hFF, pin_o, pin_oe_o;
    logic        illegal_stop_o, cpu_reset_o, fetch_reset_vector_o, module_reset_o;
    logic        ram_power_o, core_power_o, periph_clk_en_o, debug_clk_en_o, adc_run_o;
    logic        irc_run_o, crystal_oscillator_run_o, vreg_active_o, rtc_run_o, lvd_low_trip_o;
    logic [1:0]  mode_o;
    logic [31:0] q;
    int          err_total = 0, checked = 0;
    always #20 clk_i = ~clk_i;
    spc_stop_ctrl u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .stop_instr_i, .reset_pin_n_i, .shared_wake_pin_n_i,
        .wake_pin_is_out_i, .wake_pin_out_high_i, .rtc_event_i, .supply_low_i, .port_dat_i,
        .port_dir_i, .periph_en_i, .periph_dat_i, .periph_dir_i, .pin_o, .pin_oe_o,
        .illegal_stop_o, .cpu_reset_o, .fetch_reset_vector_o, .module_reset_o, .ram_power_o,
        .core_power_o, .periph_clk_en_o, .debug_clk_en_o, .adc_run_o, .irc_run_o, .crystal_oscillator_run_o,
        .vreg_active_o, .rtc_run_o, .lvd_low_trip_o, .mode_o);
    spc_far_side u_far (.clk_i, .press_reset_i, .press_wake_i,
        .reset_pin_n_o(reset_pin_n_i), .wake_pin_n_o(shared_wake_pin_n_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
            err_total++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic do_stop;
        @(posedge clk_i);
        stop_instr_i <= 1'b1;
        @(posedge clk_i);
        stop_instr_i <= 1'b0;
        #1;
    endtask
    task automatic wait_run;
        for (int n = 0; n < 300 && mode_o !== 2'h0; n++)
            tick(1);
    endtask
    task automatic t_reset;
        wb(1'b0, `SPC_ADR_STAT, 32'h0);
        chk(q, 32'h0);
        chk(ram_power_o, 1'b1);
    endtask
    task automatic t_illegal;
        wb(1'b1, `SPC_ADR_CTRL, 32'h00);
        do_stop();
        chk(illegal_stop_o, 1'b1);
        tick(2);
        chk(mode_o, 2'h0);
    endtask
    task automatic t_stop3;
        logic [7:0] ct [4] = '{8'h75, 8'h41, 8'h13, 8'h0B};
        logic [7:0] cg [4] = '{8'h1F, 8'h1D, 8'h0C, 8'h03};
        logic [5:0] ev [4] = '{6'h3F, 6'h00, 6'h26, 6'h08};
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, `SPC_ADR_CTRL, {24'h0, ct[i]});
            wb(1'b1, `SPC_ADR_CLKCFG, {24'h0, cg[i]});
            do_stop();
            tick(1);
            chk(mode_o, 2'h1);
            chk({debug_clk_en_o, adc_run_o, irc_run_o, crystal_oscillator_run_o, vreg_active_o, rtc_run_o},
                ev[i]);
            chk(periph_clk_en_o, 1'b0);
            press_reset_i <= 1'b1;
            tick(1);
            press_reset_i <= 1'b0;
            wait_run();
        end
    endtask
    task automatic t_stop2;
        wb(1'b1, `SPC_ADR_CTRL, 32'h23);
        do_stop();
        chk(mode_o, 2'h2);
        chk(core_power_o, 1'b0);
        port_dat_i <= 8'h5A;
        tick(3);
        chk(pin_o, 8'hA5);
        supply_low_i <= 1'b1;
        rtc_event_i <= 1'b1;
        tick(1);
        rtc_event_i <= 1'b0;
        tick(80);
        chk({mode_o, lvd_low_trip_o}, 3'h7);
        supply_low_i <= 1'b0;
        wait_run();
        wb(1'b0, `SPC_ADR_STAT, 32'h0);
        chk(q, 32'h1);
        wb(1'b0, `SPC_ADR_CTRL, 32'h0);
        chk(q, 32'h1);
        chk(pin_o, 8'hA5);
        periph_en_i <= 8'h0F;
        periph_dat_i <= 8'h0C;
        wb(1'b1, `SPC_ADR_STAT, 32'h2);
        tick(3);
        chk(pin_o, 8'h5C);
        wb(1'b0, `SPC_ADR_STAT, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_wake_pin;
        wb(1'b1, `SPC_ADR_CTRL, 32'h03);
        wake_pin_is_out_i <= 1'b1;
        wake_pin_out_high_i <= 1'b1;
        press_wake_i <= 1'b1;
        do_stop();
        tick(10);
        chk(mode_o, 2'h2);
        press_wake_i <= 1'b0;
        press_reset_i <= 1'b1;
        tick(6);
        chk(mode_o, 2'h3);
        press_reset_i <= 1'b0;
        wait_run();
        wb(1'b1, `SPC_ADR_STAT, 32'h2);
        wb(1'b1, `SPC_ADR_CTRL, 32'h03);
        wake_pin_is_out_i <= 1'b0;
        do_stop();
        press_wake_i <= 1'b1;
        tick(6);
        chk(mode_o, 2'h3);
        press_wake_i <= 1'b0;
        wait_run();
        wb(1'b1, `SPC_ADR_STAT, 32'h2);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        report_and_stop();
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_illegal();
        t_stop3();
        t_stop2();
        t_wake_pin();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
